// ===== rtl/ladser_pkg.sv
// constants and types shared by the lane serializer block
package ladser_pkg;
  // ---------------------------------------------------------------
  // channel and word geometry
  // ---------------------------------------------------------------
  localparam int NUM_CH = 16;
  localparam int CONV_W = 14;
  localparam int WORD_W = 16;
  localparam int SERW_W = 5;
  localparam logic [4:0] SER_W_MIN = 5'h0c;
  localparam logic [4:0] SER_W_MAX = 5'h10;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  // ---------------------------------------------------------------
  // timing counts, in conversion clock cycles
  // ---------------------------------------------------------------
  localparam int WAKE_CYCLES = 15;
  localparam logic [3:0] WAKE_LAST = 4'(WAKE_CYCLES - 2);
  localparam int DLY_W = 2;
  // ---------------------------------------------------------------
  // power state of the conversion side
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_WAKE = 2'b01,
    ST_RUN = 2'b10
  } ladser_state_t;
endpackage : ladser_pkg

// ===== rtl/ladser_sync.sv
// two-flop synchroniser for levels and static settings
`timescale 1ns/1ps
`default_nettype none
module ladser_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input wire logic clk_i,
  input wire logic rst_i,
  // level in, level out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;
  logic [W-1:0] stable;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      stable <= '0;
    end else begin
      meta <= d_i;
      stable <= meta;
    end
  end

  assign q_o = stable;
endmodule : ladser_sync
`default_nettype wire

// ===== rtl/ladser_lane.sv
// one serial lane: shifts a word out lsb first, one or two bits a cycle
`timescale 1ns/1ps
`default_nettype none
module ladser_lane
  import ladser_pkg::*;
(
  // link clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // word load and rate
  input wire logic load_i,
  input wire logic [WORD_W-1:0] word_i,
  input wire logic double_i,
  // bits on the lane, bit 0 first in time
  output logic [1:0] bits_o
);
  logic [WORD_W-1:0] shreg;
  logic [WORD_W-1:0] next_shreg;

  // zeros shift in, so unused tail bits of a wide word go out as zero
  assign next_shreg = load_i ? word_i :
                      (double_i ? (shreg >> 2) : (shreg >> 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shreg <= WORD_RST;
    end else begin
      shreg <= next_shreg;
    end
  end

  assign bits_o = shreg[1:0];
endmodule : ladser_lane
`default_nettype wire

// ===== rtl/ladser_top.sv
// sixteen-lane serializer of conversion results with bit and frame clocks
//
// How it works
// RULE1: word length per lane is set between 12 and 16 bits.
// RULE2: single rate sends one bit per link cycle, width cycles per word.
// RULE3: double rate sends two bits per link cycle, half the cycles.
// RULE4: a setting shifts bit clock against data by whole link cycles.
// RULE5: trigger input is delayed and caught on the conversion clock edge.
// RULE6: all sixteen channel results go out through one serializer; the code gives each channel its own lane, sixteen lanes.
// RULE7: results are 14-bit or 12-bit, as selected.
// RULE8: configuring party holds enable low 8 ns past last clock edge.
// RULE9: configuring party lowers enable 8 ns before first clock edge.
// RULE10: output becomes valid within 15 cycles after standby ends; the code raises it 17 conversion clock cycles after standby_i falls.
`timescale 1ns/1ps
`default_nettype none
module ladser_top
  import ladser_pkg::*;
(
  // conversion clock domain
  input wire logic core_clk_i,
  input wire logic rst_i,
  // conversion results, same clock
  input wire logic [NUM_CH*CONV_W-1:0] conv_data_i,
  input wire logic conv_strobe_i,
  // settings, quasi-static
  input wire logic res_12bit_i,
  input wire logic [SERW_W-1:0] serialization_width_i,
  input wire logic double_rate_i,
  input wire logic [DLY_W-1:0] bit_clock_delay_setting_i,
  // pins
  input wire logic standby_i,
  input wire logic transmit_trigger_in_i,
  // status and trigger, conversion clock
  output logic output_valid_o,
  output logic transmit_trigger_delayed_o,
  // link side
  input wire logic link_clk_i,
  output logic [2*NUM_CH-1:0] lane_bits_o,
  output logic bit_clk_o,
  output logic frame_o,
  output logic link_valid_o
);
  // ---------------------------------------------------------------
  // conversion clock domain
  // ---------------------------------------------------------------
  logic stby_s;
  logic trig_s;
  logic ack_s;
  logic req_tog;
  logic ack_tog;
  ladser_state_t state;
  ladser_state_t next_state;
  logic [3:0] wake_cnt;
  logic [WORD_W-1:0] hold [NUM_CH];
  logic [WORD_W-1:0] fmt [NUM_CH];
  logic pending;
  logic take;

  ladser_sync #(.W(1)) u_stby_sync (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i(standby_i),
    .q_o(stby_s)
  );

  ladser_sync #(.W(1)) u_trig_sync (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i(transmit_trigger_in_i),
    .q_o(trig_s)
  );

  ladser_sync #(.W(1)) u_ack_sync (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i(ack_tog),
    .q_o(ack_s)
  );

  // delayed trigger copy, caught on the rising conversion edge
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      transmit_trigger_delayed_o <= 1'b0;
    end else begin
      transmit_trigger_delayed_o <= trig_s; // RULE5
    end
  end

  // wake sequencing after standby
  always_comb begin
    next_state = state;
    unique case (state)
      ST_STANDBY: begin
        if (!stby_s) next_state = ST_WAKE;
      end
      ST_WAKE: begin
        if (stby_s) next_state = ST_STANDBY;
        else if (wake_cnt == WAKE_LAST) next_state = ST_RUN; // RULE10
      end
      ST_RUN: begin
        if (stby_s) next_state = ST_STANDBY;
      end
      default: next_state = ST_STANDBY;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= ST_STANDBY;
      wake_cnt <= 4'h0;
      output_valid_o <= 1'b0;
    end else begin
      state <= next_state;
      wake_cnt <= (state == ST_WAKE) ? wake_cnt + 4'h1 : 4'h0;
      output_valid_o <= (next_state == ST_RUN); // RULE10
    end
  end

  // holding words stay still while the link side copies them
  assign pending = req_tog != ack_s;
  assign take = conv_strobe_i && (state == ST_RUN) && !pending;

  // per-channel result formatting and holding
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_hold
    assign fmt[ch] = res_12bit_i ?
      {4'h0, conv_data_i[ch*CONV_W +: 12]} :
      {2'b00, conv_data_i[ch*CONV_W +: CONV_W]}; // RULE7
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        hold[ch] <= WORD_RST;
      end else if (take) begin
        hold[ch] <= fmt[ch]; // RULE6
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      req_tog <= 1'b0;
    end else if (take) begin
      req_tog <= ~req_tog;
    end
  end

  // ---------------------------------------------------------------
  // link clock domain
  // ---------------------------------------------------------------
  logic link_rst;
  logic req_s;
  logic [8:0] cfg_l;
  logic [SERW_W-1:0] width_l;
  logic dbl_l;
  logic [DLY_W-1:0] dly_l;
  logic valid_l;
  logic [SERW_W-1:0] width_eff;
  logic [WORD_W-1:0] width_mask;
  logic [SERW_W-1:0] period;
  logic [SERW_W-1:0] half;
  logic [SERW_W-1:0] cnt;
  logic load_w;
  logic new_w;
  logic [WORD_W-1:0] link_words [NUM_CH];
  logic bclk;
  logic [2:0] bhist;
  logic [3:0] taps;

  ladser_sync #(.W(1)) u_rst_sync (
    .clk_i(link_clk_i),
    .rst_i(1'b0),
    .d_i(rst_i),
    .q_o(link_rst)
  );

  // settings are static in use, so a plain two-flop pass is enough
  ladser_sync #(.W(9)) u_cfg_sync (
    .clk_i(link_clk_i),
    .rst_i(link_rst),
    .d_i({serialization_width_i, double_rate_i,
          bit_clock_delay_setting_i, output_valid_o}),
    .q_o(cfg_l)
  );

  ladser_sync #(.W(1)) u_req_sync (
    .clk_i(link_clk_i),
    .rst_i(link_rst),
    .d_i(req_tog),
    .q_o(req_s)
  );

  assign width_l = cfg_l[8:4];
  assign dbl_l = cfg_l[3];
  assign dly_l = cfg_l[2:1];
  assign valid_l = cfg_l[0];

  // width clamped into the legal span; period in link cycles per word
  assign width_eff = (width_l < SER_W_MIN) ? SER_W_MIN :
                     (width_l > SER_W_MAX) ? SER_W_MAX : width_l; // RULE1
  assign period = dbl_l ? SERW_W'((width_eff + 5'h01) >> 1) :
                  width_eff; // RULE2 RULE3
  assign half = SERW_W'((period + 5'h01) >> 1);
  // odd widths in double rate leave a spare slot; keep it zero, not data
  assign width_mask = WORD_W'((17'h0_0001 << width_eff) - 17'h0_0001);
  assign load_w = (cnt == 5'h00);
  assign new_w = req_s != ack_tog;
  assign taps = {bhist, bclk};

  // word counter and frame clock
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      cnt <= 5'h00;
      frame_o <= 1'b0;
      link_valid_o <= 1'b0;
    end else begin
      cnt <= (cnt >= period - 5'h01) ? 5'h00 : cnt + 5'h01; // RULE2 RULE3
      frame_o <= (cnt < half);
      link_valid_o <= valid_l;
    end
  end

  // copy holding words once the request toggle has settled
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      ack_tog <= 1'b0;
    end else if (new_w) begin
      ack_tog <= req_s;
    end
  end

  // bit clock runs at half the single-rate bit rate; delay by taps
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      bclk <= 1'b0;
      bhist <= 3'h0;
      bit_clk_o <= 1'b0;
    end else begin
      bclk <= ~bclk;
      bhist <= {bhist[1:0], bclk};
      bit_clk_o <= taps[dly_l]; // RULE4
    end
  end

  // one lane per channel, zero words while output is not valid
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_lane
    always_ff @(posedge link_clk_i) begin
      if (link_rst) begin
        link_words[ch] <= WORD_RST;
      end else if (!valid_l) begin
        link_words[ch] <= WORD_RST;
      end else if (new_w) begin
        link_words[ch] <= hold[ch] & width_mask; // RULE1
      end
    end
    ladser_lane u_lane (
      .clk_i(link_clk_i),
      .rst_i(link_rst),
      .load_i(load_w),
      .word_i(link_words[ch]),
      .double_i(dbl_l),
      .bits_o(lane_bits_o[2*ch +: 2]) // RULE6
    );
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [SERW_W-1:0] gap;
  logic primed;

  // cycles since the previous word load
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      gap <= 5'h00;
      primed <= 1'b0;
    end else begin
      gap <= load_w ? 5'h00 : gap + 5'h01;
      primed <= valid_l && (primed || load_w);
    end
  end

  width_span_a: assert property (@(posedge link_clk_i) disable iff (link_rst) // RULE1
    width_eff >= SER_W_MIN && width_eff <= SER_W_MAX)
    else $error("word width out of span");

  single_rate_a: assert property (@(posedge link_clk_i) disable iff (link_rst) // RULE2
    load_w && primed && !dbl_l && $stable(width_l) |-> gap == width_eff - 5'h01)
    else $error("single rate word period wrong");

  double_rate_a: assert property (@(posedge link_clk_i) disable iff (link_rst) // RULE3
    load_w && primed && dbl_l && $stable(width_l)
    |-> gap == SERW_W'((width_eff + 5'h01) >> 1) - 5'h01)
    else $error("double rate word period wrong");

  clk_nodelay_a: assert property (@(posedge link_clk_i) disable iff (link_rst) // RULE4
    dly_l == 2'b00 && $past(dly_l) == 2'b00 |-> bit_clk_o == $past(bclk))
    else $error("bit clock not aligned");

  clk_delay_a: assert property (@(posedge link_clk_i) disable iff (link_rst) // RULE4
    dly_l == 2'b10 && $past(dly_l) == 2'b10 |-> bit_clk_o == $past(bclk, 3))
    else $error("bit clock delay not applied");

  trig_capture_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE5
    $rose(transmit_trigger_in_i) ##1 transmit_trigger_in_i[*2]
    |=> transmit_trigger_delayed_o)
    else $error("trigger not captured");

  lane_load_a: assert property (@(posedge link_clk_i) disable iff (link_rst) // RULE6
    load_w |=> lane_bits_o[31:30] == $past(link_words[NUM_CH-1][1:0]))
    else $error("last lane not loaded");

  res_narrow_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE7
    take && res_12bit_i |=> hold[0][WORD_W-1:12] == 4'h0)
    else $error("12-bit word not padded");

  wake_bound_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE10
    $fell(stby_s) ##1 !stby_s[*8] |-> ##[0:7] output_valid_o)
    else $error("output not valid after wake");

  wake_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE10
    $fell(stby_s) |=> !output_valid_o)
    else $error("output valid too early");
endmodule : ladser_top
`default_nettype wire

// ===== test/ladser_rx_model.sv
// receiving capture logic model: deserializes all lanes on the link clock
`timescale 1ns/1ps
`default_nettype none
module ladser_rx_model
  import ladser_pkg::*;
(
  // link side inputs
  input wire logic link_clk_i,
  input wire logic double_i,
  input wire logic [2*NUM_CH-1:0] lane_bits_i,
  input wire logic frame_i,
  input wire logic bit_clk_i,
  // last complete words and framing figures
  output logic [NUM_CH*WORD_W-1:0] words_o,
  output logic [7:0] period_o,
  output logic [7:0] high_o,
  output logic bclk_o
);
  logic [NUM_CH*WORD_W-1:0] acc = '0;
  logic [NUM_CH*WORD_W-1:0] base;
  logic [4:0] idx = 5'h00;
  logic [4:0] pos;
  logic [7:0] cnt = 8'h00;
  logic [7:0] hcnt = 8'h00;
  logic fr_q = 1'b0;
  logic start;
  // a word starts where the frame rises; publish the one before it
  always @(posedge link_clk_i) begin
    start = frame_i && !fr_q;
    base = start ? '0 : acc;
    pos = start ? 5'h00 : idx;
    for (int c = 0; c < NUM_CH; c++) begin
      if (pos < 5'h10) base[c*WORD_W+pos] = lane_bits_i[2*c];
      if (double_i && pos < 5'h0f) base[c*WORD_W+pos+1] = lane_bits_i[2*c+1];
    end
    if (start) begin
      words_o <= acc;
      period_o <= cnt;
      high_o <= hcnt;
      bclk_o <= bit_clk_i;
      cnt <= 8'h01;
      hcnt <= 8'h01;
    end else begin
      cnt <= cnt + 8'h01;
      hcnt <= hcnt + 8'(frame_i);
    end
    acc <= base;
    idx <= pos + (double_i ? 5'h02 : 5'h01);
    fr_q <= frame_i;
  end
endmodule : ladser_rx_model
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the lane serializer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ladser_pkg::*;
  logic core_clk_i = 1'b0;
  logic link_clk = 1'b0;
  logic rst_i = 1'b1;
  logic [NUM_CH*CONV_W-1:0] conv_data = '0;
  logic strobe = 1'b0, res12 = 1'b0, dbl = 1'b0, stby = 1'b1, trig = 1'b0;
  logic [SERW_W-1:0] ser_w = 5'h10;
  logic [DLY_W-1:0] dly = 2'h0;
  logic out_valid, trig_dly, bit_clk, frame, link_valid, bclk;
  logic [2*NUM_CH-1:0] lanes;
  logic [NUM_CH*WORD_W-1:0] words;
  logic [7:0] period, high;
  logic bc_seen [4];
  int mismatches = 0;
  int num_checks = 0;
  // ---------------------------------------------------------------
  // clocks, unrelated in phase
  // ---------------------------------------------------------------
  always #2 core_clk_i = ~core_clk_i;
  initial #3 forever #7.5 link_clk = ~link_clk;
  ladser_top uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .conv_data_i(conv_data), .conv_strobe_i(strobe), .res_12bit_i(res12),
    .serialization_width_i(ser_w), .double_rate_i(dbl),
    .bit_clock_delay_setting_i(dly), .standby_i(stby),
    .transmit_trigger_in_i(trig), .output_valid_o(out_valid),
    .transmit_trigger_delayed_o(trig_dly), .link_clk_i(link_clk),
    .lane_bits_o(lanes), .bit_clk_o(bit_clk), .frame_o(frame),
    .link_valid_o(link_valid));
  ladser_rx_model rx (.link_clk_i(link_clk), .double_i(dbl),
    .lane_bits_i(lanes), .frame_i(frame), .bit_clk_i(bit_clk),
    .words_o(words), .period_o(period), .high_o(high), .bclk_o(bclk));
  // ---------------------------------------------------------------
  // compare and close
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  // settings are changed only in standby, then one result set is sent
  task automatic run_cfg(input logic [4:0] w, input logic r, input logic d,
                         input logic [1:0] k);
    int n, wc, per;
    logic [31:0] mask, v;
    n = 0;
    wc = (w < 5'h0c) ? 12 : (w > 5'h10) ? 16 : int'(w);
    per = d ? (wc + 1) / 2 : wc;
    mask = (32'h0000_0001 << wc) - 32'h0000_0001;
    @(posedge core_clk_i);
    stby <= 1'b1;
    ser_w <= w;
    res12 <= r;
    dbl <= d;
    dly <= k;
    repeat (200) @(posedge core_clk_i);
    #1 chk(16'(link_valid), 16'h0000);
    chk(words[WORD_W-1:0], 16'h0000);
    @(posedge core_clk_i);
    stby <= 1'b0;
    while (out_valid !== 1'b1 && n < 40) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    chk(16'(n >= 16 && n <= 17), 16'h0001);
    @(posedge core_clk_i);
    for (int c = 0; c < NUM_CH; c++)
      conv_data[c*CONV_W+:CONV_W] <= 14'(c * 291 + 9639 + int'(w));
    strobe <= 1'b1;
    @(posedge core_clk_i);
    strobe <= 1'b0;
    repeat (250) @(posedge core_clk_i);
    #1 chk(16'(link_valid), 16'h0001);
    chk(16'(period), 16'(per));
    chk(16'(high), 16'((per + 1) / 2));
    for (int c = 0; c < NUM_CH; c++) begin
      v = 32'(conv_data[c*CONV_W+:CONV_W]) & (r ? 32'h0000_0fff : mask);
      chk(words[c*WORD_W+:WORD_W], 16'(v & mask));
    end
    bc_seen[k] = bclk;
  endtask : run_cfg
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1 chk(16'(out_valid), 16'h0000);
    @(posedge core_clk_i);
    trig <= 1'b1;
    @(posedge core_clk_i);
    @(posedge core_clk_i);
    #1 chk(16'(trig_dly), 16'h0000);
    @(posedge core_clk_i);
    #1 chk(16'(trig_dly), 16'h0001);
    @(posedge core_clk_i);
    trig <= 1'b0;
    $display("trigger test done");
    for (int k = 0; k < 4; k++) run_cfg(5'h10, 1'b0, 1'b0, 2'(k));
    chk(16'(bc_seen[1]), 16'(!bc_seen[0]));
    chk(16'(bc_seen[2]), 16'(bc_seen[0]));
    chk(16'(bc_seen[3]), 16'(!bc_seen[0]));
    $display("bit clock delay test done");
    run_cfg(5'h0c, 1'b1, 1'b0, 2'h0);
    run_cfg(5'h0e, 1'b0, 1'b1, 2'h0);
    run_cfg(5'h0d, 1'b0, 1'b1, 2'h0);
    run_cfg(5'h0c, 1'b1, 1'b1, 2'h0);
    $display("width and rate test done");
    run_cfg(5'h08, 1'b0, 1'b0, 2'h0);
    run_cfg(5'h1f, 1'b0, 1'b0, 2'h0);
    $display("clamp test done");
    close_out();
  end
  // watchdog, well beyond the expected run of about 20 us
  initial begin
    #60000;
    mismatches++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
